/* File: hdl/mtm_pkg.sv */
// Package for the 16-bit modulo timer: register map, field layout, reset values, types.
// Assumes an Avalon-MM slave with 32-bit data and word-aligned byte addresses.
package mtm_pkg;
   // Register byte offsets
   localparam logic [3:0] ADDR_CTRL  = 4'h0;   // status/control
   localparam logic [3:0] ADDR_CNTH  = 4'h4;   // count high byte
   localparam logic [3:0] ADDR_CNTL  = 4'h8;   // count low byte
   localparam logic [3:0] ADDR_LIMH  = 4'hc;   // wrap limit high byte (index 3)
   localparam logic [3:0] ADDR_LIML  = 4'h0;   // wrap limit low byte, bank 1
   localparam int         ADDR_W     = 5;
   // Control field positions
   localparam int BIT_FLAG  = 7;
   localparam int BIT_IE    = 6;
   localparam int BIT_CLR   = 5;
   localparam int BIT_HALT  = 4;
   localparam int SRC_LO    = 8;
   localparam int PS_LO     = 0;
   localparam int PS_W      = 4;
   localparam int SRC_W     = 2;
   // Reset values
   localparam logic [15:0] CNT_RST   = 16'h0000;
   localparam logic [15:0] LIM_RST   = 16'h0000;
   localparam logic [3:0]  PS_RST    = 4'h0;
   localparam logic [3:0]  PS_MAX    = 4'h8;
   localparam logic [7:0]  PRE_RST   = 8'h00;
   // Count sources
   typedef enum logic [1:0] {
      MTM_SRC_BUS  = 2'h0,
      MTM_SRC_FIX  = 2'h1,
      MTM_SRC_FALL = 2'h2,
      MTM_SRC_RISE = 2'h3
   } mtm_src_e;
   // Bus transaction bundle
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              rd;
      logic              wr;
      logic [31:0]       wdata;
   } mtm_bus_s;
endpackage

/* File: hdl/mtm_timer.sv */
// 16-bit modulo timer with Avalon-MM register slave, prescaler and source select.
// Assumes inputs synchronous to mclk_in except ext_count_pin and fixed_rate_clock_in, which are synchronised here.
// Notes on behaviour
// - Modes: stopped, free-running with zero limit, modulo with nonzero limit.
// - Reset halts and zeroes counter, zero limit, bus clock source, divide by one.
// - Writing control with halt bit clear starts counting.
// - Source is bus clock, fixed-rate clock, or falling or rising pin edges.
// - Changing source while running keeps the count.
// - Prescaler divides source by 1 through 256 in powers of two.
// - Changing prescale while running keeps the count.
// - Limit holds 0x0001 to 0xFFFF; zero means free-running.
// - Counter increments at prescaled rate, wraps to zero after matching limit.
// - Flag sets on each step to zero, from the limit value or from 0xFFFF when free-running.
// - An overflow between that read and write cancels the clear.
// - Writing one to the clear command also clears the flag.
// - Interrupt request is flag and enable together.
// - Source codes 00 bus, 01 fixed, 10 falling, 11 rising; reset to 00.
// - Prescale codes 0 to 8 divide by 1 to 256; higher codes divide by 256.
// - Reading either count byte latches both until the next read of either count byte.
// - Limit bytes buffered, applied together; second byte of first pair after reset clears count now.
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module mtm_timer #(
   parameter int CNT_W = 16                          // Counter width
) (
   input  wire logic                      mclk_in,         // Bus clock, 20 MHz
   input  wire logic                      sys_rst_in,      // Synchronous reset, active high
   input  wire logic [mtm_pkg::ADDR_W-1:0] avs_address_in,  // Byte address
   input  wire logic                      avs_read_in,     // Read request
   input  wire logic                      avs_write_in,    // Write request
   input  wire logic [31:0]               avs_writedata_in,// Write data
   input  wire logic [3:0]                avs_byteenable_in, // Byte enables
   output logic      [31:0]               avs_readdata_out,  // Read data
   output logic                           avs_waitrequest_out, // Wait request
   input  wire logic                      fixed_rate_clock_in, // Fixed-rate tick, level
   input  wire logic                      ext_count_pin_in,    // External count pin
   output logic                           wrap_irq_out     // Overflow interrupt request
);
   // Bus request bundle
   mtm_pkg::mtm_bus_s bus;
   assign bus.addr  = avs_address_in;
   assign bus.rd    = avs_read_in;
   assign bus.wr    = avs_write_in;
   assign bus.wdata = avs_writedata_in;

   // Register state
   logic [CNT_W-1:0]          cnt_q;
   logic [CNT_W-1:0]          lim_q;
   logic [7:0]                lim_buf_q;
   logic                      lim_half_q;
   logic                      lim_first_q;
   logic                      lim_pend_q;
   logic [CNT_W-1:0]          lim_new_q;
   logic [CNT_W-1:0]          cnt_buf_q;
   logic                      cnt_half_q;
   logic                      halt_q;
   logic                      ie_q;
   logic                      flag_q;
   logic                      arm_q;
   logic [1:0]                src_q;
   logic [mtm_pkg::PS_W-1:0]  ps_q;
   logic [7:0]                pre_q;
   logic                      pin_s1_q;
   logic                      pin_s2_q;
   logic                      pin_s3_q;
   logic                      fix_s1_q;
   logic                      fix_s2_q;
   logic                      fix_s3_q;
   logic                      ack_q;
   logic [31:0]               rdata_q;
   logic                      irq_q;

   // Access decode; one wait cycle before each answer
   wire req      = (bus.rd | bus.wr) & ~ack_q;
   wire wr_go    = bus.wr & ack_q;
   wire rd_go    = bus.rd & ack_q;
   wire bank1    = bus.addr[4];
   wire [3:0] lo = bus.addr[3:0];
   wire sel_ctrl = ~bank1 & (lo == mtm_pkg::ADDR_CTRL);
   wire sel_cnth = ~bank1 & (lo == mtm_pkg::ADDR_CNTH);
   wire sel_cntl = ~bank1 & (lo == mtm_pkg::ADDR_CNTL);
   wire sel_limh = ~bank1 & (lo == mtm_pkg::ADDR_LIMH);
   wire sel_liml =  bank1 & (lo == mtm_pkg::ADDR_LIML);
   wire be0      = avs_byteenable_in[0];
   wire be1      = avs_byteenable_in[1];

   // Control write fields
   wire wr_ctrl  = wr_go & sel_ctrl;
   wire w_flag   = bus.wdata[mtm_pkg::BIT_FLAG];
   wire w_clr    = wr_ctrl & be0 & bus.wdata[mtm_pkg::BIT_CLR];
   wire wr_limh  = wr_go & sel_limh & be0;
   wire wr_liml  = wr_go & sel_liml & be0;

   // Source edge tick selection
   wire pin_fall = pin_s3_q & ~pin_s2_q;
   wire pin_rise = ~pin_s3_q & pin_s2_q;
   wire fix_rise = ~fix_s3_q & fix_s2_q;
   logic src_tick;
   always_comb begin
      case (src_q)
         mtm_pkg::MTM_SRC_BUS:  src_tick = 1'b1;
         mtm_pkg::MTM_SRC_FIX:  src_tick = fix_rise;
         mtm_pkg::MTM_SRC_FALL: src_tick = pin_fall;
         default:               src_tick = pin_rise;
      endcase
   end

   // Prescale mask, codes above 8 clamp to 256
   function automatic logic [7:0] ps_mask(input logic [3:0] ps);
      logic [3:0] p;
      p = (ps > mtm_pkg::PS_MAX) ? mtm_pkg::PS_MAX : ps;
      ps_mask = 8'((9'h001 << p) - 9'h001);
   endfunction
   wire [7:0] mask   = ps_mask(ps_q);
   wire running      = ~halt_q;
   wire pre_done     = ((pre_q & mask) == mask);
   wire step         = running & src_tick & pre_done;
   wire modulo_mode  = (lim_q != mtm_pkg::LIM_RST);
   wire at_top       = modulo_mode ? (cnt_q == lim_q) : (&cnt_q);
   wire wrap         = step & at_top;
   wire lim_imm      = (wr_limh | wr_liml) & lim_half_q & lim_first_q;
   wire [CNT_W-1:0] lim_cat = {lim_buf_q, bus.wdata[7:0]};

   // Prescaler keeps counting across source or divisor changes
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in | w_clr | halt_q) begin
         pre_q <= mtm_pkg::PRE_RST;
      end else if (src_tick) begin
         pre_q <= pre_done ? mtm_pkg::PRE_RST : pre_q + 8'h01;
      end
   end

   // Input synchronisers and edge history
   always_ff @(posedge mclk_in) begin
      pin_s1_q <= ext_count_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      fix_s1_q <= fixed_rate_clock_in;
      fix_s2_q <= fix_s1_q;
      fix_s3_q <= fix_s2_q;
   end

   // Counter and wrap limit
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in | w_clr) begin
         cnt_q <= mtm_pkg::CNT_RST;
      end else if (lim_imm) begin
         cnt_q <= mtm_pkg::CNT_RST;
      end else if (wrap) begin
         cnt_q <= mtm_pkg::CNT_RST;
      end else if (step) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Limit write buffering: bytes in either order; first pair after reset applied at once, later pairs at next wrap or while halted
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         lim_q       <= mtm_pkg::LIM_RST;
         lim_buf_q   <= 8'h00;
         lim_half_q  <= 1'b0;
         lim_first_q <= 1'b1;
         lim_pend_q  <= 1'b0;
         lim_new_q   <= mtm_pkg::LIM_RST;
      end else if (w_clr) begin
         lim_half_q <= 1'b0;
      end else if (wr_limh | wr_liml) begin
         if (!lim_half_q) begin
            lim_half_q <= 1'b1;
            lim_buf_q  <= bus.wdata[7:0];
            lim_new_q  <= wr_limh ? {bus.wdata[7:0], lim_q[7:0]} : {lim_q[15:8], bus.wdata[7:0]};
         end else begin
            lim_half_q  <= 1'b0;
            lim_first_q <= 1'b0;
            if (lim_first_q) begin
               lim_q <= wr_liml ? lim_cat : {bus.wdata[7:0], lim_buf_q};
            end else begin
               lim_pend_q <= 1'b1;
               lim_new_q  <= wr_liml ? lim_cat : {bus.wdata[7:0], lim_buf_q};
            end
         end
      end else if (lim_pend_q & (wrap | halt_q)) begin
         lim_q      <= lim_new_q;
         lim_pend_q <= 1'b0;
      end
   end

   // Control bits; reset stops the counter
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         halt_q <= 1'b1;
         ie_q   <= 1'b0;
         src_q  <= mtm_pkg::MTM_SRC_BUS;
         ps_q   <= mtm_pkg::PS_RST;
      end else if (wr_ctrl) begin
         if (be0) begin
            halt_q <= bus.wdata[mtm_pkg::BIT_HALT];
            ie_q   <= bus.wdata[mtm_pkg::BIT_IE];
            ps_q   <= bus.wdata[mtm_pkg::PS_LO +: mtm_pkg::PS_W];
         end
         if (be1) begin
            src_q <= bus.wdata[mtm_pkg::SRC_LO +: mtm_pkg::SRC_W];
         end
      end
   end

   // Overflow flag with two-step clear; a new wrap wins and disarms
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         flag_q <= 1'b0;
         arm_q  <= 1'b0;
      end else if (wrap) begin
         flag_q <= 1'b1;
         arm_q  <= 1'b0;
      end else if (w_clr) begin
         flag_q <= 1'b0;
         arm_q  <= 1'b0;
      end else if (wr_ctrl & be0 & ~w_flag & arm_q) begin
         flag_q <= 1'b0;
         arm_q  <= 1'b0;
      end else if (rd_go & sel_ctrl & flag_q) begin
         arm_q <= 1'b1;
      end
   end

   // Coherent count read buffer
   // The snapshot is taken on the edge that also loads the read data, so the
   // byte returned first and the byte held for later come from one count value.
   wire cnt_sel  = sel_cnth | sel_cntl;
   wire cnt_snap = req & bus.rd & cnt_sel & ~cnt_half_q;
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in | w_clr) begin
         cnt_half_q <= 1'b0;
         cnt_buf_q  <= mtm_pkg::CNT_RST;
      end else if (cnt_snap) begin
         cnt_buf_q <= cnt_q;
      end else if (rd_go & cnt_sel) begin
         cnt_half_q <= ~cnt_half_q;
      end
   end

   // Read mux
   wire [CNT_W-1:0] cnt_view = cnt_half_q ? cnt_buf_q : cnt_q;
   wire [31:0] ctrl_word = {22'h000000, src_q, flag_q, ie_q, 1'b0, halt_q, ps_q};
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h00000000;
      if (sel_ctrl) rmux = ctrl_word;
      if (sel_cnth) rmux = {24'h000000, cnt_view[15:8]};
      if (sel_cntl) rmux = {24'h000000, cnt_view[7:0]};
      if (sel_limh) rmux = {24'h000000, lim_q[15:8]};
      if (sel_liml) rmux = {24'h000000, lim_q[7:0]};
   end

   // Bus answer and interrupt output
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
         irq_q   <= 1'b0;
      end else begin
         ack_q   <= req;
         rdata_q <= rmux;
         irq_q   <= (flag_q | wrap) & ie_q;
      end
   end

   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = ~ack_q;
   assign wrap_irq_out        = irq_q;
endmodule
`default_nettype wire

/* File: tb/mtm_timer_properties.sv */
// Checker for bus handshake, reset state and interrupt of the modulo timer.
// Assumes a bind to mtm_timer; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module mtm_timer_chk #(
   parameter int CNT_W = 16                       // Counter width
) (
   input wire logic                       mclk_in,             // Clock
   input wire logic                       sys_rst_in,          // Reset
   input wire logic [mtm_pkg::ADDR_W-1:0] avs_address_in,      // Address
   input wire logic                       avs_read_in,         // Read
   input wire logic                       avs_write_in,        // Write
   input wire logic [31:0]                avs_writedata_in,    // Write data
   input wire logic [3:0]                 avs_byteenable_in,   // Byte enables
   input wire logic [31:0]                avs_readdata_out,    // Read data
   input wire logic                       avs_waitrequest_out, // Wait
   input wire logic                       fixed_rate_clock_in, // Fixed tick
   input wire logic                       ext_count_pin_in,    // Pin
   input wire logic                       wrap_irq_out         // Interrupt
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   // Bus decode helpers
   wire logic req = avs_read_in | avs_write_in;
   wire logic ans = !avs_waitrequest_out;
   wire logic ctl = avs_address_in == mtm_pkg::ADDR_CTRL;
   // Bus timing and field relations
   AST_RST: assert property ($past(sys_rst_in) |-> avs_waitrequest_out && !wrap_irq_out)
      else $error("reset left bus or interrupt active");
   AST_IDLE: assert property (!req |=> avs_waitrequest_out)
      else $error("answer without request");
   AST_ANS: assert property (req && avs_waitrequest_out |=> ans)
      else $error("request not answered after one wait state");
   AST_ONE: assert property (ans |=> avs_waitrequest_out)
      else $error("answer longer than one cycle");
   AST_CLR0: assert property (ans && avs_read_in && ctl |-> !avs_readdata_out[5])
      else $error("clear command bit reads one");
   AST_IE_OFF: assert property (ans && avs_write_in && ctl && avs_byteenable_in[0]
      && !avs_writedata_in[6] |-> ##2 !wrap_irq_out) else $error("irq with enable off");
   AST_IRQ: assert property (ans && avs_read_in && ctl && avs_readdata_out[7]
      && avs_readdata_out[6] |-> ##[0:2] wrap_irq_out) else $error("irq missing");
   AST_RDHI: assert property (ans && avs_read_in
      && avs_address_in inside {5'h04, 5'h08, 5'h0c, 5'h10} |-> avs_readdata_out[31:8] == 24'h0)
      else $error("byte register upper bits set");
   // Main scenarios seen
   COV_IRQ: cover property (wrap_irq_out);
   COV_WR: cover property (ans && avs_write_in);
   COV_FLAG: cover property (ans && avs_read_in && ctl && avs_readdata_out[7]);
endmodule
`default_nettype wire

/* File: tb/tb_modulo_timer_16bit.sv */
// Self-checking bench for the modulo timer, driving its Avalon-MM slave.
// Assumes mtm_pkg, mtm_timer and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_modulo_timer_16bit;
   logic                       mclk = 0, sys_rst = 1, av_rd = 0, av_wr = 0, frc = 0, pin = 0;
   logic [mtm_pkg::ADDR_W-1:0] av_addr = 0;
   logic [31:0]                av_wdata = 0, rdata, q;
   logic                       wreq, irq;
   logic [7:0]                 tick = 0;
   logic [15:0]                v, v1;
   int                         n_fail = 0, cmp_count = 0, p, s, per;
   always #25 mclk = ~mclk;
   // Fixed-rate clock of period 8, pin of period 16
   always @(posedge mclk) begin
      tick <= tick + 8'h1;
      frc <= tick[2];
      pin <= tick[3];
   end
   mtm_timer DUT (.mclk_in(mclk), .sys_rst_in(sys_rst), .avs_address_in(av_addr),
      .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .fixed_rate_clock_in(frc), .ext_count_pin_in(pin), .wrap_irq_out(irq));
   // Verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic chk_rng(input logic [15:0] g, input int lo, input int hi);
      cmp_count++;
      if (^g === 1'bx || g < lo || g > hi) begin
         n_fail++;
         $display("BAD %0t count %h out of %0d..%0d", $time, g, lo, hi);
      end
   endtask
   // One bus transfer, held until waitrequest is sampled low
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      int i;
      av_addr <= a;
      av_wr <= w;
      av_rd <= !w;
      av_wdata <= d;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (wreq !== 1'b0 && i < 40);
      q = rdata;
      av_rd <= 0;
      av_wr <= 0;
      if (wreq !== 1'b0) begin
         n_fail++;
         $display("BAD %0t bus timeout", $time);
         print_verdict();
      end else @(posedge mclk);
   endtask
   task automatic ctl(input logic f, ie, c, h, input logic [3:0] pp, input logic [1:0] ss);
      bus(5'h00, 1, {22'h0, ss, f, ie, c, h, pp});
   endtask
   task automatic cnt();
      logic [7:0] h;
      bus(5'h04, 0, 0);
      h = q[7:0];
      bus(5'h08, 0, 0);
      v = {h, q[7:0]};
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      sys_rst <= 0;
      @(posedge mclk);
      bus(5'h00, 0, 0);
      chk(q, 32'h10);
      cnt();
      chk(v, 0);
      bus(5'h0c, 0, 0);
      chk(q, 0);
      bus(5'h14, 0, 0);
      chk(q, 0);
      $display("test reset done");
      // Prescale codes 0 to 9 at bus clock, then the other three sources
      for (int k = 0; k < 13; k++) begin
         p = k < 10 ? k : 0;
         s = k < 10 ? 0 : k - 9;
         per = s == 1 ? 8 : s > 1 ? 16 : 1 << (p > 8 ? 8 : p);
         ctl(1, 0, 1, 1, p[3:0], s[1:0]);
         ctl(1, 0, 0, 0, p[3:0], s[1:0]);
         repeat (512) @(posedge mclk);
         ctl(1, 0, 0, 1, p[3:0], s[1:0]);
         cnt();
         chk_rng(v, 508 / per, (524 + per) / per);
      end
      $display("test rates done");
      ctl(1, 0, 0, 0, 0, 0);
      cnt();
      v1 = v;
      ctl(1, 0, 0, 0, 4'h3, 0);
      cnt();
      chk_rng(v, v1 + 1, v1 + 30);
      v1 = v;
      ctl(1, 0, 0, 0, 0, 2'h1);
      cnt();
      chk_rng(v, v1, v1 + 20);
      $display("test running changes done");
      ctl(1, 0, 0, 1, 0, 0);
      bus(5'h0c, 1, 0);
      bus(5'h10, 1, 5);
      cnt();
      chk(v, 0);
      bus(5'h10, 0, 0);
      chk(q, 5);
      ctl(1, 0, 0, 0, 0, 0);
      repeat (100) @(posedge mclk);
      ctl(1, 0, 0, 1, 0, 0);
      cnt();
      chk_rng(v, 0, 5);
      bus(5'h00, 0, 0);
      chk(q[7], 1);
      ctl(0, 0, 0, 1, 0, 0);
      bus(5'h00, 0, 0);
      chk(q[7], 0);
      ctl(1, 0, 0, 0, 0, 0);
      repeat (30) @(posedge mclk);
      bus(5'h00, 0, 0);
      chk(q[7], 1);
      repeat (20) @(posedge mclk);
      ctl(0, 0, 0, 1, 0, 0);
      bus(5'h00, 0, 0);
      chk(q[7], 1);
      ctl(1, 0, 1, 1, 0, 0);
      bus(5'h00, 0, 0);
      chk(q, 32'h10);
      cnt();
      chk(v, 0);
      $display("test modulo and flag done");
      ctl(1, 1, 0, 0, 0, 0);
      repeat (20) @(posedge mclk);
      bus(5'h00, 0, 0);
      chk(irq, 1);
      ctl(1, 0, 0, 1, 0, 0);
      repeat (3) @(posedge mclk);
      chk(irq, 0);
      $display("test interrupt done");
      ctl(1, 0, 1, 1, 0, 0);
      bus(5'h0c, 1, 0);
      bus(5'h10, 1, 0);
      ctl(1, 0, 0, 0, 0, 0);
      repeat (65500) @(posedge mclk);
      bus(5'h00, 0, 0);
      chk(q[7], 0);
      repeat (100) @(posedge mclk);
      ctl(1, 0, 0, 1, 0, 0);
      bus(5'h00, 0, 0);
      chk(q[7], 1);
      cnt();
      chk_rng(v, 1, 200);
      $display("test free-run rollover done");
      print_verdict();
   end
endmodule
bind mtm_timer mtm_timer_chk #(.CNT_W(CNT_W)) u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .fixed_rate_clock_in(fixed_rate_clock_in), .ext_count_pin_in(ext_count_pin_in),
   .wrap_irq_out(wrap_irq_out));
`default_nettype wire
